// file: rco_pkg.sv
// Purpose: Constants and types for the second recovered clock output select.
// Assumes: APB register access, 32-bit data, one clock domain.
// Notes: Field positions, reset values and the legal code limits live here.
// Summary of operation
// [RULE_01] The output is driven only while the enable bit 15 is one; it resets to zero.
// [RULE_02] Source field 14:11 picks PHY0 to PHY3 with codes 0 to 3; higher codes are reserved.
// [RULE_03] Frequency field 10:8 picks 25, 125 or 31.25 MHz with codes 0 to 2; the rest are reserved.
// [RULE_04] Squelch level 00 holds the output low on link down or unstable, on 1000 master or 10 Mb/s, or in EEE at 100 Mb/s or 1000 slave.
// [RULE_05] Level 01 is level 00 but also clocks in 1000 master and 10 Mb/s, and in EEE while LP_IDLE is received.
// [RULE_06] Level 10 forces the output low only while the selected link is down.
// [RULE_07] Level 11 never squelches, even with the link down.
// [RULE_08] A high external squelch pin holds the output low whatever the fields say.
// [RULE_09] Field 2:0 resets to 000 and picks the serial media clock (000) or copper receiver clock (001); others are reserved.
// [RULE_10] A reserved code in source, frequency or clock selection holds the output low.
// [RULE_11] Reserved bits 7:6 and 3 read as zero and ignore writes.
package rco_pkg;

   localparam logic [7:0] CTRL_OFF = 8'h18;
   localparam logic [7:0] STAT_OFF = 8'h1C;

   localparam int EN_BIT = 15;
   localparam int SRC_LSB = 11;
   localparam int FREQ_LSB = 8;
   localparam int SQ_LSB = 4;
   localparam int CSEL_LSB = 0;

   localparam logic [3:0] SRC_RST = 4'h0;
   localparam logic [2:0] FREQ_RST = 3'h0;
   localparam logic [1:0] SQ_RST = 2'h0;
   localparam logic [2:0] CSEL_RST = 3'h0;

   localparam logic [3:0] SRC_MAX = 4'h3;
   localparam logic [2:0] FREQ_MAX = 3'h2;
   localparam logic [2:0] CSEL_MAX = 3'h1;

   typedef enum logic [1:0] {
      RCO_SQ_AUTO = 2'b00,
      RCO_SQ_RELAX = 2'b01,
      RCO_SQ_LINK = 2'b10,
      RCO_SQ_OFF = 2'b11
   } rco_sq_e;

   typedef enum logic [1:0] {
      RCO_SPD_10 = 2'b00,
      RCO_SPD_100 = 2'b01,
      RCO_SPD_1000 = 2'b10
   } rco_spd_e;

   // Link state reported by one PHY core
   typedef struct packed {
      logic up;
      logic stable;
      rco_spd_e speed;
      logic master;
      logic eee;
      logic lp_idle;
   } rco_link_s;

   typedef struct packed {
      logic en;
      logic [3:0] src;
      logic [2:0] freq;
      rco_sq_e sq;
      logic [2:0] csel;
   } rco_ctrl_s;

   typedef struct packed {
      rco_ctrl_s ctrl;
      logic clk_out;
      logic [31:0] rdata;
   } rco_state_s;

endpackage

// file: rco_clk_sel.sv
// Purpose: Control register and gating of the second recovered clock output.
// Assumes: Tapped recovered clocks and link state arrive synchronous to i_clk_sys.
// Notes: Output is a registered copy of the selected tap, one cycle late.
`timescale 1ns/1ns
`default_nettype none

module rco_clk_sel #(
   parameter int NUM_PHY = 4,
   parameter int NUM_FREQ = 3
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [NUM_PHY-1:0][1:0][NUM_FREQ-1:0] i_phy_clk,
   input wire rco_pkg::rco_link_s [NUM_PHY-1:0] i_phy_link,
   input wire logic i_clk_squelch,
   output logic o_recovered_clock_out_second
);

   rco_pkg::rco_state_s st_q;
   rco_pkg::rco_state_s st_d;

   logic setup;
   logic access;
   logic hit_ctrl;
   logic hit_stat;
   logic cfg_bad;
   logic link_sq;
   logic gate_open;
   logic tap;
   rco_pkg::rco_link_s lnk;
   logic [15:0] ctrl_rd;
   logic [15:0] ctrl_wr;
   logic [31:0] stat_rd;

   assign setup = i_psel & ~i_penable;
   assign access = i_psel & i_penable;
   assign hit_ctrl = (i_paddr == rco_pkg::CTRL_OFF);
   assign hit_stat = (i_paddr == rco_pkg::STAT_OFF);

   // Zero wait states; unmapped addresses answer with an error
   assign o_pready = 1'b1;
   assign o_pslverr = access & ~(hit_ctrl | hit_stat);
   assign o_prdata = st_q.rdata;
   assign o_recovered_clock_out_second = st_q.clk_out;

   // Reserved codes never reach a tap index
   assign cfg_bad = (st_q.ctrl.src > rco_pkg::SRC_MAX)
      | (st_q.ctrl.freq > rco_pkg::FREQ_MAX)
      | (st_q.ctrl.csel > rco_pkg::CSEL_MAX); // RULE_10

   always_comb begin
      lnk = '0;
      tap = 1'b0;
      if (!cfg_bad) begin
         lnk = i_phy_link[st_q.ctrl.src[1:0]]; // RULE_02
         tap = i_phy_clk[st_q.ctrl.src[1:0]][st_q.ctrl.csel[0]][st_q.ctrl.freq[1:0]]; // RULE_03 RULE_09
      end
   end

   // Link-driven squelch per level
   always_comb begin
      link_sq = 1'b1;
      unique case (st_q.ctrl.sq)
         rco_pkg::RCO_SQ_AUTO: begin
            link_sq = ~lnk.up | ~lnk.stable
               | (lnk.speed == rco_pkg::RCO_SPD_10)
               | ((lnk.speed == rco_pkg::RCO_SPD_1000) & lnk.master)
               | (lnk.eee & ((lnk.speed == rco_pkg::RCO_SPD_100)
                  | ((lnk.speed == rco_pkg::RCO_SPD_1000) & ~lnk.master))); // RULE_04
         end
         rco_pkg::RCO_SQ_RELAX: begin
            link_sq = ~lnk.up | ~lnk.stable
               | (lnk.eee & ~lnk.lp_idle
                  & ((lnk.speed == rco_pkg::RCO_SPD_100)
                  | ((lnk.speed == rco_pkg::RCO_SPD_1000) & ~lnk.master))); // RULE_05
         end
         rco_pkg::RCO_SQ_LINK: begin
            link_sq = ~lnk.up; // RULE_06
         end
         rco_pkg::RCO_SQ_OFF: begin
            link_sq = 1'b0; // RULE_07
         end
      endcase
   end

   // Pin squelch overrides every field
   assign gate_open = st_q.ctrl.en & ~cfg_bad & ~link_sq & ~i_clk_squelch; // RULE_01 RULE_08

   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[rco_pkg::EN_BIT] = st_q.ctrl.en;
      ctrl_rd[rco_pkg::SRC_LSB +: 4] = st_q.ctrl.src;
      ctrl_rd[rco_pkg::FREQ_LSB +: 3] = st_q.ctrl.freq;
      ctrl_rd[rco_pkg::SQ_LSB +: 2] = st_q.ctrl.sq;
      ctrl_rd[rco_pkg::CSEL_LSB +: 3] = st_q.ctrl.csel; // RULE_11
   end

   // Byte lanes merged over the current value
   always_comb begin
      ctrl_wr = ctrl_rd;
      if (i_pstrb[0]) begin
         ctrl_wr[7:0] = i_pwdata[7:0];
      end
      if (i_pstrb[1]) begin
         ctrl_wr[15:8] = i_pwdata[15:8];
      end
   end

   assign stat_rd = {28'h0000000, i_clk_squelch, link_sq, cfg_bad, gate_open};

   always_comb begin
      st_d = st_q;
      st_d.clk_out = gate_open & tap;
      if (setup) begin
         // Read data is captured in setup so it comes from a flop
         st_d.rdata = '0;
         if (!i_pwrite && hit_ctrl) begin
            st_d.rdata = {16'h0000, ctrl_rd};
         end
         if (!i_pwrite && hit_stat) begin
            st_d.rdata = stat_rd;
         end
      end
      if (access && i_pwrite && hit_ctrl) begin
         st_d.ctrl.en = ctrl_wr[rco_pkg::EN_BIT];
         st_d.ctrl.src = ctrl_wr[rco_pkg::SRC_LSB +: 4];
         st_d.ctrl.freq = ctrl_wr[rco_pkg::FREQ_LSB +: 3];
         st_d.ctrl.sq = rco_pkg::rco_sq_e'(ctrl_wr[rco_pkg::SQ_LSB +: 2]);
         st_d.ctrl.csel = ctrl_wr[rco_pkg::CSEL_LSB +: 3]; // RULE_11
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st_q.ctrl.en <= 1'b0; // RULE_01
         st_q.ctrl.src <= rco_pkg::SRC_RST;
         st_q.ctrl.freq <= rco_pkg::FREQ_RST;
         st_q.ctrl.sq <= rco_pkg::RCO_SQ_AUTO;
         st_q.ctrl.csel <= rco_pkg::CSEL_RST; // RULE_09
         st_q.clk_out <= 1'b0;
         st_q.rdata <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

`default_nettype wire

// file: rco_clk_sel_props.sv
// Purpose: Port checks for rco_clk_sel
// Assumes: Whole-word register writes
// Notes: A shadow of the control word stands in for the hidden register
`timescale 1ns/1ns
`default_nettype none
module rco_clk_sel_props #(parameter int NUM_PHY = 4, parameter int NUM_FREQ = 3) (
   input wire logic i_clk_sys, i_reset, i_psel, i_penable, i_pwrite, i_clk_squelch,
   input wire logic [7:0] i_paddr,
   input wire logic [3:0] i_pstrb,
   input wire logic [31:0] i_pwdata, o_prdata,
   input wire logic o_pready, o_pslverr, o_recovered_clock_out_second,
   input wire logic [NUM_PHY-1:0][1:0][NUM_FREQ-1:0] i_phy_clk,
   input wire rco_pkg::rco_link_s [NUM_PHY-1:0] i_phy_link
);
   logic [15:0] c_q;
   wire o = o_recovered_clock_out_second;
   // Out of range on a reserved rate; only looked at when the gate is open
   wire t = i_phy_clk[c_q[12:11]][c_q[0]][c_q[9:8]];
   always_ff @(posedge i_clk_sys)
      if (i_reset) c_q <= 16'h0000;
      else if (i_psel && i_penable && i_pwrite && i_paddr == 8'h18)
         c_q <= i_pwdata[15:0] & 16'hFF37;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   en_off_a: assert property (!c_q[15] |=> !o) else $error("clock when off");
   src_bad_a: assert property (c_q[14:13] != 2'h0 |=> !o) else $error("bad source");
   freq_bad_a: assert property (c_q[10:8] > 3'h2 |=> !o) else $error("bad rate");
   pin_sq_a: assert property (i_clk_squelch |=> !o) else $error("pin ignored");
   tap_sel_a: assert property (o |-> $past(t)) else $error("wrong tap");
   link_sq_a: assert property (c_q[5:4] == 2'h2 && !i_phy_link[c_q[12:11]].up
      |=> !o) else $error("link down clock");
   no_sq_a: assert property (c_q[15:13] == 3'h4 && c_q[10:8] < 3'h3 && c_q[5:4] == 2'h3
      && c_q[2:1] == 2'h0 && !i_clk_squelch |=> o == $past(t)) else $error("clock lost");
   read_back_a: assert property (i_psel && i_penable && !i_pwrite && i_paddr == 8'h18
      |-> o_prdata == {16'h0000, c_q}) else $error("bad read");
endmodule
bind rco_clk_sel rco_clk_sel_props #(.NUM_PHY(NUM_PHY), .NUM_FREQ(NUM_FREQ)) u_props (.*);
`default_nettype wire

// file: rco_board.sv
// Purpose: Board timing circuit fed by the recovered clock
// Assumes: Sampled on the system clock
// Notes: Listens only
`timescale 1ns/1ns
`default_nettype none
module rco_board (
   input wire logic i_clk,
   input wire logic i_rclk,
   output var int o_edges = 0
);
   logic q = 0;
   always @(posedge i_clk) begin
      q <= i_rclk;
      o_edges <= o_edges + int'(i_rclk && !q);
   end
endmodule
`default_nettype wire

// file: test_recovered_clock_output_select.sv
// Purpose: Self-checking bench for rco_clk_sel
// Assumes: Zero-wait register bus
// Notes: Output is compared every cycle with a reference gate
`timescale 1ns/1ns
`default_nettype none
module test_recovered_clock_output_select;
   logic clk = 0, rst = 1, ps = 0, pe = 0, pw = 0, sq = 0, rdy, er, o, ex = 0, e;
   logic [7:0] ad = 8'h00;
   logic [31:0] wd = 0, rd, q, r = 18126;
   logic [15:0] c = 0, v;
   logic [3:0][1:0][2:0] tp = 0;
   rco_pkg::rco_link_s [3:0] lk = 0;
   int failures = 0, checks_done = 0, edges;
   initial forever #5 clk = ~clk;
   rco_clk_sel u_dut (.i_clk_sys(clk), .i_reset(rst), .i_psel(ps), .i_penable(pe),
      .i_pwrite(pw), .i_paddr(ad), .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata(rd),
      .o_pready(rdy), .o_pslverr(er), .i_phy_clk(tp), .i_phy_link(lk),
      .i_clk_squelch(sq), .o_recovered_clock_out_second(o));
   rco_board u_board (.i_clk(clk), .i_rclk(o), .o_edges(edges));
   function logic gate(logic [15:0] x, rco_pkg::rco_link_s l, logic p);
      logic s, m;
      s = l.eee && (l.speed == rco_pkg::RCO_SPD_100 || l.speed[1] && !l.master);
      m = l.speed == rco_pkg::RCO_SPD_10 || l.speed[1] && l.master;
      case (x[5:4])
         2'h0: gate = l.up && l.stable && !m && !s;
         2'h1: gate = l.up && l.stable && !(s && !l.lp_idle);
         2'h2: gate = l.up;
         default: gate = 1'b1;
      endcase
      return gate && x[15] && x[14:11] < 4 && x[10:8] < 3 && x[2:0] < 2 && !p;
   endfunction
   task chk(input string n, input logic [31:0] s, x);
      checks_done++;
      if (s !== x) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask
   task end_of_test;
      if (failures == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      {ps, pe, pw, ad, wd} <= {2'b10, w, a, d};
      @(posedge clk);
      pe <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (!rdy && n < 20);
      {q, e} = {rd, er};
      if (rdy !== 1'b1) begin failures++; end_of_test; end
      {ps, pe} <= 2'b00;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      r <= {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
      tp <= r[23:0];
      // Speed code 11 is not a legal link speed
      lk <= r[27:0] & ~((r[27:0] << 1) & 28'h2040810);
      sq <= r[31:29] == 3'h0;
      if (!rst) chk("clk_out", o, ex);
      ex <= !rst && gate(c, lk[c[12:11]], sq) && tp[c[12:11]][c[0]][c[9:8]];
      if (rst) c <= 0;
      else if (ps && pe && pw && ad == 8'h18) c <= wd[15:0] & 16'hFF37;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      apb(0, 8'h18, 0);
      chk("ctrl_reset", q, 0);
      for (int i = 0; i < 64; i++) begin
         v = i[0] ? r[15:0] : {3'h4, r[12:11], 1'b0, r[9] ? 2'h0 : r[9:8], 2'h0, i[2:1], 3'h0, r[0]};
         apb(1, 8'h18, {16'h0, v});
         apb(0, 8'h18, 0);
         chk("ctrl_read", q, v & 16'hFF37);
         repeat (r[3:0]) @(posedge clk);
      end
      apb(0, 8'h40, 0);
      chk("bad_addr_err", e, 1);
      chk("bad_addr_data", q, 0);
      chk("edges", edges > 0, 1);
      end_of_test;
   end
endmodule
`default_nettype wire
